// file: hw/tfcs_top.v
// trip force and compare event select block with avalon-mm slave
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tfcs_map.vh"
module tfcs_top (
    input  wire        sys_clk_in,
    input  wire        rst_b_in,
    input  wire [4:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    input  wire [2:0]  trip_zone_in,
    input  wire [2:0]  comparator_in,
    output reg         cmp_a_event_one_out,
    output reg         cmp_a_event_two_out,
    output reg         cmp_b_event_one_out,
    output reg         cmp_b_event_two_out,
    output reg         one_shot_trip_out,
    output reg         per_cycle_trip_out,
    output reg         irq_out
);
    // access phases of the bus slave, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACK  = 2'b10;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [15:0] evsel_ff;
    reg  [15:0] srcsel_ff;
    reg  [15:0] flag_ff;
    reg  [15:0] mask_ff;
    reg  [15:0] trip_ff;
    reg  [15:0] nxt_flag;
    reg  [15:0] nxt_trip;
    reg  [15:0] nxt_rdata;
    reg  [3:0]  qual_ff;
    wire [3:0]  src_w;
    wire [3:0]  qual_w;
    wire        req_w;
    wire        take_w;
    wire        lo_be_w;
    wire        hi_be_w;
    wire [15:0] wdata_w;
    wire [15:0] force_w;
    wire [15:0] clear_w;
    wire [15:0] w1c_w;
    wire [15:0] live_w;

    // match of the bus address against one register offset
    function hit;
        input [4:0] addr;
        input [4:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // merge write data into a register under the byte enables
    function [15:0] merge;
        input [15:0] old;
        input [15:0] neu;
        input        lo;
        input        hi;
        begin
            merge = {hi ? neu[15:8] : old[15:8],
                     lo ? neu[7:0]  : old[7:0]};
        end
    endfunction

    assign req_w   = avs_read_in | avs_write_in;
    assign take_w  = state_ff[1] & req_w;
    assign lo_be_w = avs_byteenable_in[0];
    assign hi_be_w = avs_byteenable_in[1];
    assign wdata_w = avs_writedata_in[15:0];

    // R1 R2 R3 R4 R5 R6: write-one force pulses, writes of zero do nothing
    assign force_w = (take_w & avs_write_in &
                      hit(avs_address_in, `TFCS_OFS_FORCE)) ?
                     (merge(16'h0000, wdata_w, lo_be_w, hi_be_w) &
                      `TFCS_TRIP_MSK) : 16'h0000;

    // R17: write-one clear pulses for the trip conditions
    assign clear_w = (take_w & avs_write_in &
                      hit(avs_address_in, `TFCS_OFS_CLEAR)) ?
                     (merge(16'h0000, wdata_w, lo_be_w, hi_be_w) &
                      `TFCS_TRIP_MSK) : 16'h0000;

    // write-one clear of the sticky flags
    assign w1c_w = (take_w & avs_write_in &
                    hit(avs_address_in, `TFCS_OFS_FLAG)) ?
                   (merge(16'h0000, wdata_w, lo_be_w, hi_be_w) &
                    `TFCS_TRIP_MSK) : 16'h0000;

    // live qualified compare events placed at their trip positions
    assign live_w = {9'h000, qual_ff, 3'h0};

    // R16: four compare inputs, each from its own selector field
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_src
            tfcs_src_mux u_src (
                .sel_in  (srcsel_ff[4*gi+3:4*gi]),
                .tz_in   (trip_zone_in),
                .cmp_in  (comparator_in),
                .src_out (src_w[gi])
            );
        end
    endgenerate

    // R18: four events qualified every clock from their select codes
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_evt
            tfcs_evt_qual u_qual (
                .code_in (evsel_ff[3*gi+2:3*gi]),
                .high_in (gi < 2 ? src_w[0] : src_w[2]),
                .low_in  (gi < 2 ? src_w[1] : src_w[3]),
                .evt_out (qual_w[gi])
            );
        end
    endgenerate

    // registered event levels
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            qual_ff <= 4'h0;
        end else begin
            qual_ff <= qual_w;
        end
    end

    // bus slave phases: one wait cycle, then the access completes
    always @* begin
        case (state_ff)
            ST_IDLE: nxt_state = req_w ? ST_ACK : ST_IDLE;
            ST_ACK:  nxt_state = ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // read data gathered while waitrequest is still high
    always @* begin
        nxt_rdata = 16'h0000;
        // R7: force and clear registers read back zero
        if (hit(avs_address_in, `TFCS_OFS_EVSEL)) begin
            // R9: reserved top bits read zero
            nxt_rdata = evsel_ff & `TFCS_EVSEL_MSK;
        end else if (hit(avs_address_in, `TFCS_OFS_SRCSEL)) begin
            nxt_rdata = srcsel_ff;
        end else if (hit(avs_address_in, `TFCS_OFS_FLAG)) begin
            nxt_rdata = flag_ff;
        end else if (hit(avs_address_in, `TFCS_OFS_MASK)) begin
            nxt_rdata = mask_ff;
        end
    end

    // sticky flags and trip conditions, a set beats a clear
    always @* begin
        // R1 R2 R3 R4 R5 R6: force sets flag alongside the trip
        nxt_flag = ((flag_ff & ~w1c_w & ~clear_w) | force_w | live_w) &
                   `TFCS_TRIP_MSK;
        // R17: clear drops the condition unless it is raised again
        nxt_trip = ((trip_ff & ~clear_w) | force_w | live_w) &
                   `TFCS_TRIP_MSK;
    end

    // bus slave handshake and read data
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_ff            <= ST_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            state_ff            <= nxt_state;
            avs_waitrequest_out <= ~(state_ff[0] & req_w);
            if (state_ff[0] & avs_read_in) begin
                avs_readdata_out <= {16'h0000, nxt_rdata};
            end
        end
    end

    // software-written configuration registers
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            evsel_ff  <= `TFCS_EVSEL_RST;
            srcsel_ff <= `TFCS_SRCSEL_RST;
            mask_ff   <= `TFCS_MASK_RST;
        end else if (take_w & avs_write_in) begin
            // R8 R9: event select fields, reserved bits kept zero
            if (hit(avs_address_in, `TFCS_OFS_EVSEL)) begin
                evsel_ff <= merge(evsel_ff, wdata_w, lo_be_w, hi_be_w) &
                            `TFCS_EVSEL_MSK;
            end
            // R16: source selector fields
            if (hit(avs_address_in, `TFCS_OFS_SRCSEL)) begin
                srcsel_ff <= merge(srcsel_ff, wdata_w, lo_be_w, hi_be_w);
            end
            if (hit(avs_address_in, `TFCS_OFS_MASK)) begin
                mask_ff <= merge(mask_ff, wdata_w, lo_be_w, hi_be_w) &
                           `TFCS_TRIP_MSK;
            end
        end
    end

    // flag and trip state
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_ff <= 16'h0000;
            trip_ff <= 16'h0000;
        end else begin
            flag_ff <= nxt_flag;
            trip_ff <= nxt_trip;
        end
    end

    // trip outputs and interrupt, all registered
    always @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            per_cycle_trip_out  <= 1'b0;
            one_shot_trip_out   <= 1'b0;
            cmp_a_event_one_out <= 1'b0;
            cmp_a_event_two_out <= 1'b0;
            cmp_b_event_one_out <= 1'b0;
            cmp_b_event_two_out <= 1'b0;
            irq_out             <= 1'b0;
        end else begin
            // R5 R6: software trip events
            per_cycle_trip_out  <= nxt_trip[`TFCS_BIT_PCT];
            one_shot_trip_out   <= nxt_trip[`TFCS_BIT_ONE_SHOT];
            // R1 R2 R3 R4: compare event trip conditions
            cmp_a_event_one_out <= nxt_trip[`TFCS_BIT_A1];
            cmp_a_event_two_out <= nxt_trip[`TFCS_BIT_A1+1];
            cmp_b_event_one_out <= nxt_trip[`TFCS_BIT_A1+2];
            cmp_b_event_two_out <= nxt_trip[`TFCS_BIT_B2];
            irq_out             <= |(nxt_flag & mask_ff);
        end
    end
endmodule

// file: hw/tfcs_map.vh
// register map, field positions and reset values of the trip force block
// Behaviour
// R1: writing 1 to force bit 6 raises compare-B event-two trip and flag
// R2: writing 1 to force bit 5 raises compare-B event-one trip and flag
// R3: writing 1 to force bit 4 raises compare-A event-two trip and flag
// R4: writing 1 to force bit 3 raises compare-A event-one trip and flag
// R5: writing 1 to force bit 2 makes a one-shot trip and sets its flag
// R6: writing 1 to force bit 1 makes a per-cycle trip and sets its flag
// R7: force bits ignore written zeros and always read back zero
// R8: select bits 11-9 hold B event two, 8-6 B event one; 000 disables
// R9: select bits 5-3 A event two, 2-0 A event one; 15-12 read zero
// R10: B codes 001 and 010 trip on high input low or high
// R11: B codes 011 and 100 trip on low input low or high
// R12: B code 101 trips on low high and high low; 110, 111 reserved
// R13: A codes 001 and 010 trip on high input low or high
// R14: A codes 011 and 100 trip on low input low or high
// R15: A code 101 trips on low high and high low; 110, 111 reserved
// R16: each compare input picks its source by a 4-bit selector code
// R17: writing 1 to a clear bit clears that trip; zero ignored, reads zero
// R18: events are evaluated every clock; disabled or reserved codes never trip
`ifndef TFCS_MAP_VH
`define TFCS_MAP_VH

// byte addresses on the register bus
`define TFCS_ADDR_W            5
`define TFCS_OFS_FORCE         5'h00
`define TFCS_OFS_EVSEL         5'h04
`define TFCS_OFS_SRCSEL        5'h08
`define TFCS_OFS_FLAG          5'h0C
`define TFCS_OFS_CLEAR         5'h10
`define TFCS_OFS_MASK          5'h14

// trip bit positions, shared by force, flag, clear and mask
`define TFCS_BIT_PCT           1
`define TFCS_BIT_ONE_SHOT      2
`define TFCS_BIT_A1            3
`define TFCS_BIT_B2            6
`define TFCS_TRIP_MSK          16'h007E

// event select mask and reset values of the select and mask registers
`define TFCS_EVSEL_MSK         16'h0FFF
`define TFCS_EVSEL_RST         16'h0000
`define TFCS_SRCSEL_RST        16'h0000
`define TFCS_MASK_RST          16'h0000

// event select codes
`define TFCS_EV_OFF            3'h0
`define TFCS_EV_HI_LOW         3'h1
`define TFCS_EV_HI_HIGH        3'h2
`define TFCS_EV_LO_LOW         3'h3
`define TFCS_EV_LO_HIGH        3'h4
`define TFCS_EV_LOHI_HILO      3'h5

// source select codes
`define TFCS_SRC_TZ_BASE       4'h0
`define TFCS_SRC_TZ_LAST       4'h2
`define TFCS_SRC_CMP_BASE      4'h8
`define TFCS_SRC_CMP_LAST      4'hA

`endif

// file: hw/tfcs_src_mux.v
// source picker for one compare input
`timescale 1ns/1ps
`include "tfcs_map.vh"
module tfcs_src_mux (
    input  wire [3:0] sel_in,
    input  wire [2:0] tz_in,
    input  wire [2:0] cmp_in,
    output reg        src_out
);
    // R16: selector code picks trip-zone or comparator
    always @* begin
        src_out = 1'b0;
        if (sel_in <= `TFCS_SRC_TZ_LAST) begin
            src_out = tz_in[sel_in[1:0]];
        end else if (sel_in >= `TFCS_SRC_CMP_BASE &&
                     sel_in <= `TFCS_SRC_CMP_LAST) begin
            src_out = cmp_in[sel_in[1:0]];
        end
    end
endmodule

// file: hw/tfcs_evt_qual.v
// qualifier of one compare event from its high and low inputs
`timescale 1ns/1ps
`include "tfcs_map.vh"
module tfcs_evt_qual (
    input  wire [2:0] code_in,
    input  wire       high_in,
    input  wire       low_in,
    output reg        evt_out
);
    // R18: reserved and disabled codes fall to default, no event
    always @* begin
        case (code_in)
            // R10 R13: high input low or high
            `TFCS_EV_HI_LOW:    evt_out = ~high_in;
            `TFCS_EV_HI_HIGH:   evt_out = high_in;
            // R11 R14: low input low or high
            `TFCS_EV_LO_LOW:    evt_out = ~low_in;
            `TFCS_EV_LO_HIGH:   evt_out = low_in;
            // R12 R15: low high with high low
            `TFCS_EV_LOHI_HILO: evt_out = low_in & ~high_in;
            default:            evt_out = 1'b0;
        endcase
    end
endmodule

// file: test/tfcs_checker.sv
// assertion checker on the ports of the trip force block
`timescale 1ns/1ps
`include "tfcs_map.vh"
module tfcs_checker (
    input wire        sys_clk_in,
    input wire        rst_b_in,
    input wire [4:0]  avs_address_in,
    input wire        avs_read_in,
    input wire        avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0]  avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire        avs_waitrequest_out,
    input wire        cmp_a_event_one_out,
    input wire        cmp_b_event_two_out,
    input wire        one_shot_trip_out,
    input wire        per_cycle_trip_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_b_in);
    // completing accesses to the force, clear and select registers
    wire done = !avs_waitrequest_out;
    wire wfrc = avs_write_in && done && avs_byteenable_in[0]
                && avs_address_in == `TFCS_OFS_FORCE;
    wire wclr = avs_write_in && done && avs_address_in == `TFCS_OFS_CLEAR;
    wire rd_f = avs_read_in && done && avs_address_in == `TFCS_OFS_FORCE;
    wire rd_s = avs_read_in && done && avs_address_in == `TFCS_OFS_EVSEL;
    wire [31:0] wd = avs_writedata_in;

    AST_FRC_PCT: assert property (wfrc && wd[1] |=> per_cycle_trip_out)
        else $error("forced per-cycle trip not raised");
    AST_FRC_ONESHOT: assert property (wfrc && wd[2] |=> one_shot_trip_out)
        else $error("forced one-shot trip not raised");
    AST_FRC_A1: assert property (wfrc && wd[3] |=> cmp_a_event_one_out)
        else $error("forced compare A event one not raised");
    AST_FRC_B2: assert property (wfrc && wd[6] |=> cmp_b_event_two_out)
        else $error("forced compare B event two not raised");
    AST_FRC_ZERO: assert property (wfrc && wd[6:1] == 6'h00
        && !per_cycle_trip_out |=> !per_cycle_trip_out)
        else $error("zero force write raised a trip");
    AST_RD_FRC: assert property (rd_f |-> avs_readdata_out == 32'h0)
        else $error("force register read nonzero");
    AST_RD_SEL: assert property (rd_s |-> avs_readdata_out[31:12] == 20'h0)
        else $error("select reserved bits read nonzero");
    AST_HOLD_ONESHOT: assert property (one_shot_trip_out && !wclr
        |=> one_shot_trip_out) else $error("one-shot trip dropped");
    AST_WAIT: assert property ((avs_read_in || avs_write_in)
        && avs_waitrequest_out |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("access not answered after one wait cycle");
endmodule

bind tfcs_top tfcs_checker i_tfcs_checker (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .cmp_a_event_one_out(cmp_a_event_one_out),
    .cmp_b_event_two_out(cmp_b_event_two_out),
    .one_shot_trip_out(one_shot_trip_out),
    .per_cycle_trip_out(per_cycle_trip_out));

// file: test/tfcs_cmp_src.sv
// far-side model driving trip-zone and comparator levels
`timescale 1ns/1ps
module tfcs_cmp_src (
    input  wire       sys_clk_in,
    input  wire       hi_in,
    input  wire       lo_in,
    output reg  [2:0] trip_zone_out,
    output reg  [2:0] comparator_out
);
    initial begin
        trip_zone_out  = 3'h0;
        comparator_out = 3'h0;
    end
    // source lines used
    // line 0 carries the high level, line 1 the low; line 2 toggles
    always @(posedge sys_clk_in) begin
        trip_zone_out  <= {~trip_zone_out[2], lo_in, hi_in};
        comparator_out <= {~comparator_out[2], lo_in, hi_in};
    end
endmodule

// file: test/tfcs_tb_top.sv
// testbench of the trip force and compare event select block
`timescale 1ns/1ps
`include "tfcs_map.vh"
module tfcs_tb_top;
    reg         sys_clk_in;
    reg         rst_b_in;
    reg  [4:0]  adr;
    reg         rd_s;
    reg         wr_s;
    reg  [31:0] wd;
    reg         hi;
    reg         lo;
    reg  [31:0] v;
    wire [31:0] rdat;
    wire        wreq;
    wire        irq;
    wire [2:0]  tz;
    wire [2:0]  cmp;
    wire        a1, a2, b1, b2, oneshot, pct;
    wire [6:0]  trip = {b2, b1, a2, a1, oneshot, pct, 1'b0};
    integer     n_errors, n_tests, c, k;

    tfcs_top i_tfcs_top (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s),
        .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
        .trip_zone_in(tz), .comparator_in(cmp),
        .cmp_a_event_one_out(a1), .cmp_a_event_two_out(a2),
        .cmp_b_event_one_out(b1), .cmp_b_event_two_out(b2),
        .one_shot_trip_out(oneshot), .per_cycle_trip_out(pct),
        .irq_out(irq));
    tfcs_cmp_src i_tfcs_cmp_src (.sys_clk_in(sys_clk_in), .hi_in(hi),
        .lo_in(lo), .trip_zone_out(tz), .comparator_out(cmp));

    // one bus access, held until waitrequest is seen low
    task acc(input w, input [4:0] a, input [15:0] d);
        begin
            @(posedge sys_clk_in);
            adr <= a;
            wd <= {16'h0000, d};
            wr_s <= w;
            rd_s <= ~w;
            @(posedge sys_clk_in);
            while (wreq !== 1'b0) @(posedge sys_clk_in);
            v = rdat;
            wr_s <= 1'b0;
            rd_s <= 1'b0;
        end
    endtask
    task chk_reg(input [31:0] g, input [31:0] e);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task chk_trip(input [6:0] e);
        begin
            @(posedge sys_clk_in);
            chk_reg({25'h0, trip}, {25'h0, e});
        end
    endtask
    // irq is registered on the completing edge, so look one edge later
    task chk_irq(input e);
        begin
            @(posedge sys_clk_in);
            chk_reg({31'h0, irq}, {31'h0, e});
        end
    endtask
    // expected event for a select code and the two input levels
    function ev(input [2:0] cd, input h, input l);
        case (cd)
            3'h1: ev = ~h;
            3'h2: ev = h;
            3'h3: ev = ~l;
            3'h4: ev = l;
            3'h5: ev = l & ~h;
            default: ev = 1'b0;
        endcase
    endfunction
    task complete_run;
        begin
            if (n_errors == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_errors = n_errors + 1;
        complete_run;
    end
    initial begin
        rst_b_in = 1'b0; adr = 5'h00; rd_s = 1'b0; wr_s = 1'b0;
        wd = 32'h0; hi = 1'b0; lo = 1'b0; n_errors = 0; n_tests = 0;
        repeat (12) @(posedge sys_clk_in);
        rst_b_in <= 1'b1;
        acc(0, `TFCS_OFS_EVSEL, 16'h0); chk_reg(v, 32'h0);
        acc(1, `TFCS_OFS_EVSEL, 16'hFFFF);
        acc(0, `TFCS_OFS_EVSEL, 16'h0); chk_reg(v, 32'h0FFF);
        acc(1, `TFCS_OFS_EVSEL, 16'h0);
        acc(1, `TFCS_OFS_FORCE, 16'h0); chk_trip(7'h00);
        acc(0, 5'h1C, 16'h0); chk_reg(v, 32'h0);
        // each force bit alone: trip, read-back, flag, then clear
        for (k = 1; k < 7; k = k + 1) begin
            acc(1, `TFCS_OFS_FORCE, 16'h1 << k);
            chk_trip(7'h01 << k);
            acc(0, `TFCS_OFS_FORCE, 16'h0); chk_reg(v, 32'h0);
            acc(0, `TFCS_OFS_FLAG, 16'h0); chk_reg(v, 32'h1 << k);
            acc(1, `TFCS_OFS_CLEAR, 16'h007E); chk_trip(7'h00);
        end
        // interrupt masked, raised, then cleared through the flag
        acc(1, `TFCS_OFS_MASK, 16'h0004);
        acc(1, `TFCS_OFS_FORCE, 16'h0002); chk_irq(1'b0);
        acc(1, `TFCS_OFS_FORCE, 16'h0004); chk_irq(1'b1);
        acc(1, `TFCS_OFS_FLAG, 16'h0004); chk_irq(1'b0);
        acc(1, `TFCS_OFS_CLEAR, 16'h007E); chk_trip(7'h00);
        // every select code against every input level pair
        acc(1, `TFCS_OFS_SRCSEL, 16'h9810);
        for (c = 0; c < 8; c = c + 1) begin
            for (k = 0; k < 4; k = k + 1) begin
                hi <= k[1];
                lo <= k[0];
                acc(1, `TFCS_OFS_EVSEL, {4'h0, c[2:0], c[2:0], c[2:0], c[2:0]});
                repeat (3) @(posedge sys_clk_in);
                chk_trip({{4{ev(c[2:0], k[1], k[0])}}, 3'h0});
                acc(1, `TFCS_OFS_EVSEL, 16'h0);
                acc(1, `TFCS_OFS_CLEAR, 16'h007E); chk_trip(7'h00);
            end
        end
        complete_run;
    end
endmodule
